// ---- hptc_pkg.sv ----
package hptc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] FAULT_STAT_ADDR = 8'h04;
  localparam logic [7:0] CONV_STAT_ADDR = 8'h05;
  localparam logic [7:0] FAULT_MASK_ADDR = 8'h07;
  localparam logic [7:0] CONV_MASK_ADDR = 8'h08;
  localparam logic [7:0] CTRL_ADDR = 8'h09;

  // ==========================================================
  // Field positions
  localparam int TMO_BIT = 2;
  localparam int UVLO_BIT = 1;
  localparam int FLT_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int EOC_BIT = 0;
  localparam int TRIG_BIT = 7;
  localparam int RAM_BIT = 6;
  localparam int CLK_BIT = 5;
  localparam int MODE_MSB = 4;
  localparam int MODE_LSB = 0;

  // Source index in the flattened status vector
  localparam int SRC_FLT = 0;
  localparam int SRC_UVLO = 1;
  localparam int SRC_TMO = 2;
  localparam int SRC_EOC = 3;
  localparam int SRC_BUSY = 4;
  localparam int N_SRC = 5;

  // ==========================================================
  // Reset values
  localparam logic [2:0] FAULT_MASK_RST = 3'h0;
  localparam logic [1:0] CONV_MASK_RST = 2'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RD_DATA_RST = 8'h00;
  localparam logic STATUS_RST = 1'b0;

  // ==========================================================
  // Driver interface mode codes
  localparam logic [4:0] MODE_OFF = 5'h00;
  localparam logic [4:0] MODE_TRIG_STORED = 5'h0C;
  localparam logic [4:0] MODE_RAM_PAT = 5'h12;

endpackage

// ---- hptc_sticky.sv ----
`timescale 1ns/1ps

module hptc_sticky_bit
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Event, software clear and mask enable
  input wire logic set_evt,
  input wire logic clr_req,
  input wire logic mask_en,
  // State
  output logic status,
  output logic pending
);

  typedef struct packed
  {
    logic flag;
  } hptc_sticky_t;

  hptc_sticky_t st_q;
  hptc_sticky_t st_d;

  // ==========================================================
  // Latch regardless of mask; a set beats a clear
  always_comb
  begin
    st_d = st_q;
    st_d.flag = set_evt | (st_q.flag & ~clr_req); // RL10
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '{flag: hptc_pkg::STATUS_RST};
    else
      st_q <= st_d;
  end

  assign status = st_q.flag;
  assign pending = st_q.flag & mask_en; // RL10

  // ==========================================================
  // Checks
  a_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n) // RL10
    set_evt |=> status)
    else $error("event lost at clear");

  a_masked_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // RL10
    !mask_en |-> !pending)
    else $error("masked source pending");

endmodule // hptc_sticky_bit

// ---- hptc_regs.sv ----
`timescale 1ns/1ps

// Contract
// (RL1) Fault mask bit 2 passes the vibration-timeout interrupt when 1.
// (RL2) Fault mask bit 1 passes the drive-supply lockout interrupt when 1.
// (RL3) Fault mask bit 0 passes the fault-change interrupt when 1.
// (RL4) Register 0x08 bit 1 gates busy change, bit 0 conversion done.
// (RL5) Writing control bit 7 to 1 in trigger modes starts vibration; code starts only if stored bit 7 was 0.
// (RL6) Control bit 6 enables the pattern RAM.
// (RL7) Host keeps clock enable set through vibration, clears mode first.
// (RL8) Register 0x09 holds mode in 4:0, clock enable bit 5, all RW.
// (RL9) Mode zero disables the driver; other codes select interface modes.
// (RL10) Interrupt asserts only for status and mask both 1; status latches.
module hptc_regs
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port from the serial control engine
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Interrupt sources
  input wire logic vib_timeout_irq,
  input wire logic drive_supply_lockout_irq,
  input wire logic fault_change_irq,
  input wire logic conv_busy_change_irq,
  input wire logic conv_done_irq,
  // Interrupt and driver controls
  output logic irq,
  output logic [4:0] driver_interface_mode,
  output logic driver_clock_enable,
  output logic pattern_ram_enable,
  output logic driver_enable,
  output logic vib_start
);

  typedef struct packed
  {
    logic [2:0] fault_mask;
    logic [1:0] conv_mask;
    logic [7:0] ctrl;
    logic [7:0] rd_data;
    logic start;
  } hptc_state_t;

  hptc_state_t st_q;
  hptc_state_t st_d;

  logic [hptc_pkg::N_SRC-1:0] src_evt;
  logic [hptc_pkg::N_SRC-1:0] src_clr;
  logic [hptc_pkg::N_SRC-1:0] src_mask;
  logic [hptc_pkg::N_SRC-1:0] stat;
  logic [hptc_pkg::N_SRC-1:0] pend;
  logic wr_fault_stat;
  logic wr_conv_stat;
  logic wr_ctrl;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] target);
    hit = en && (a == target);
  endfunction

  // Only the register-triggered modes accept a software start
  function automatic logic is_trig_mode(input logic [4:0] m);
    is_trig_mode = (m == hptc_pkg::MODE_TRIG_STORED) ||
                   (m == hptc_pkg::MODE_RAM_PAT);
  endfunction

  assign wr_fault_stat = hit(reg_wr_en, reg_addr, hptc_pkg::FAULT_STAT_ADDR);
  assign wr_conv_stat = hit(reg_wr_en, reg_addr, hptc_pkg::CONV_STAT_ADDR);
  assign wr_ctrl = hit(reg_wr_en, reg_addr, hptc_pkg::CTRL_ADDR);

  // ==========================================================
  // Interrupt sources
  assign src_evt[hptc_pkg::SRC_FLT] = fault_change_irq;
  assign src_evt[hptc_pkg::SRC_UVLO] = drive_supply_lockout_irq;
  assign src_evt[hptc_pkg::SRC_TMO] = vib_timeout_irq;
  assign src_evt[hptc_pkg::SRC_EOC] = conv_done_irq;
  assign src_evt[hptc_pkg::SRC_BUSY] = conv_busy_change_irq;

  // Status clears by writing 1 to the bit
  assign src_clr[2:0] = {3{wr_fault_stat}} & reg_wr_data[2:0];
  assign src_clr[4:3] = {2{wr_conv_stat}} & reg_wr_data[1:0];

  assign src_mask[hptc_pkg::SRC_FLT] = st_q.fault_mask[hptc_pkg::FLT_BIT]; // RL3
  assign src_mask[hptc_pkg::SRC_UVLO] = st_q.fault_mask[hptc_pkg::UVLO_BIT]; // RL2
  assign src_mask[hptc_pkg::SRC_TMO] = st_q.fault_mask[hptc_pkg::TMO_BIT]; // RL1
  assign src_mask[hptc_pkg::SRC_EOC] = st_q.conv_mask[hptc_pkg::EOC_BIT]; // RL4
  assign src_mask[hptc_pkg::SRC_BUSY] = st_q.conv_mask[hptc_pkg::BUSY_BIT]; // RL4

  generate
    for (genvar i = 0; i < hptc_pkg::N_SRC; i++)
    begin : g_src
      hptc_sticky_bit u_bit
      (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set_evt(src_evt[i]),
        .clr_req(src_clr[i]),
        .mask_en(src_mask[i]),
        .status(stat[i]),
        .pending(pend[i])
      );
    end
  endgenerate

  assign irq = |pend; // RL10

  // ==========================================================
  // Register writes and reads
  always_comb
  begin
    st_d = st_q;
    st_d.start = 1'b0;
    if (hit(reg_wr_en, reg_addr, hptc_pkg::FAULT_MASK_ADDR))
      st_d.fault_mask = reg_wr_data[2:0]; // RL1
    if (hit(reg_wr_en, reg_addr, hptc_pkg::CONV_MASK_ADDR))
      st_d.conv_mask = reg_wr_data[1:0]; // RL4
    if (wr_ctrl)
    begin
      st_d.ctrl = reg_wr_data; // RL8
      // Start only on a rising trigger bit; rewriting 1 restarts nothing
      st_d.start = reg_wr_data[hptc_pkg::TRIG_BIT] &&
                   !st_q.ctrl[hptc_pkg::TRIG_BIT] &&
                   is_trig_mode(reg_wr_data[4:0]); // RL5
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        hptc_pkg::FAULT_STAT_ADDR: st_d.rd_data = {5'h00, stat[2:0]};
        hptc_pkg::CONV_STAT_ADDR: st_d.rd_data = {6'h00, stat[4:3]};
        hptc_pkg::FAULT_MASK_ADDR: st_d.rd_data = {5'h00, st_q.fault_mask};
        hptc_pkg::CONV_MASK_ADDR: st_d.rd_data = {6'h00, st_q.conv_mask};
        hptc_pkg::CTRL_ADDR: st_d.rd_data = st_q.ctrl; // RL8
        default: st_d.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '{fault_mask: hptc_pkg::FAULT_MASK_RST,
                conv_mask: hptc_pkg::CONV_MASK_RST,
                ctrl: hptc_pkg::CTRL_RST,
                rd_data: hptc_pkg::RD_DATA_RST,
                start: 1'b0};
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Driver controls
  assign reg_rd_data = st_q.rd_data;
  assign driver_interface_mode = st_q.ctrl[hptc_pkg::MODE_MSB:
                                           hptc_pkg::MODE_LSB]; // RL8
  // Clock sequencing around the mode is the host's duty; not enforced
  assign driver_clock_enable = st_q.ctrl[hptc_pkg::CLK_BIT]; // RL7
  assign pattern_ram_enable = st_q.ctrl[hptc_pkg::RAM_BIT]; // RL6
  assign driver_enable = (driver_interface_mode != hptc_pkg::MODE_OFF); // RL9
  assign vib_start = st_q.start; // RL5

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_tmo_gate_pass: assert property ( // RL1
    (stat[hptc_pkg::SRC_TMO] && st_q.fault_mask[hptc_pkg::TMO_BIT]) |-> irq)
    else $error("unmasked timeout without irq");

  a_uvlo_gate_block: assert property ( // RL2
    (irq && !st_q.fault_mask[hptc_pkg::UVLO_BIT]) |->
    (stat & {st_q.conv_mask, st_q.fault_mask[2], 1'b0,
             st_q.fault_mask[0]}) != 5'h00)
    else $error("masked lockout raised irq");

  a_flt_mask_write: assert property ( // RL3
    hit(reg_wr_en, reg_addr, hptc_pkg::FAULT_MASK_ADDR) |=>
    st_q.fault_mask[hptc_pkg::FLT_BIT] == $past(reg_wr_data[0]))
    else $error("fault-change mask not stored");

  a_conv_mask_read: assert property ( // RL4
    (reg_rd_en && reg_addr == hptc_pkg::CONV_MASK_ADDR) |=>
    reg_rd_data == {6'h00, $past(st_q.conv_mask)})
    else $error("converter mask readback wrong");

  a_trig_start: assert property ( // RL5
    (wr_ctrl && reg_wr_data[7] && !st_q.ctrl[7] &&
     is_trig_mode(reg_wr_data[4:0])) |=> vib_start ##1 !vib_start)
    else $error("trigger write gave no single start pulse");

  a_trig_zero_quiet: assert property ( // RL5
    (wr_ctrl && !reg_wr_data[7]) |=> !vib_start)
    else $error("start from writing zero");

  a_ram_enable: assert property ( // RL6
    wr_ctrl |=> pattern_ram_enable == $past(reg_wr_data[6]))
    else $error("pattern ram enable mismatch");

  a_ctrl_readback: assert property ( // RL8
    (reg_rd_en && reg_addr == hptc_pkg::CTRL_ADDR) |=>
    reg_rd_data == $past(st_q.ctrl))
    else $error("control readback wrong");

  a_mode_off: assert property ( // RL9
    (wr_ctrl && reg_wr_data[4:0] == 5'h00) |=> !driver_enable)
    else $error("driver enabled in off mode");

  a_irq_level: assert property ( // RL10
    irq == ((stat & {st_q.conv_mask, st_q.fault_mask}) != 5'h00))
    else $error("irq not equal to masked status");

  a_latch_masked: assert property ( // RL10
    (vib_timeout_irq && !st_q.fault_mask[hptc_pkg::TMO_BIT]) |=>
    stat[hptc_pkg::SRC_TMO])
    else $error("masked event did not latch");

  c_start: cover property (vib_start);
  c_irq_rise: cover property (!irq ##1 irq);
  c_set_on_clear: cover property (src_evt[0] && src_clr[0]);
  c_mode_ram: cover property (driver_interface_mode == hptc_pkg::MODE_RAM_PAT
                              && pattern_ram_enable);

endmodule // hptc_regs

// ---- hptc_host.sv ----
`timescale 1ns/1ps

module hptc_host
(
  // Clock
  input wire logic core_clk,
  // Register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);
  // ====
  // Bus cycles
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end

  // Idle lines invert so a stale value never looks live
  task automatic idle();
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wr_data = ~reg_wr_data;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge core_clk);
    #1;
    idle();
  end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rd_data;
    idle();
  end
  endtask

  // ====
  // Vibration sequences
  task automatic start_vib(input logic [4:0] m);
  begin
    wr(hptc_pkg::CTRL_ADDR, 8'h20);
    wr(hptc_pkg::CTRL_ADDR, {3'b101, m});
  end
  endtask

  task automatic stop_vib();
  begin
    wr(hptc_pkg::CTRL_ADDR, 8'h20);
    wr(hptc_pkg::CTRL_ADDR, 8'h00);
  end
  endtask
endmodule // hptc_host

// ---- tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] src = 5'h00;
  logic wr_en, rd_en, irq, clk_en, ram_en, drv_en, vib;
  logic [7:0] addr, wdata, rdata, a, b, v, w;
  logic [4:0] mode;
  logic [4:0] modes [3] = '{5'h0C, 5'h12, 5'h01};
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h7ed1ea9b;

  always #5 core_clk = ~core_clk;

  hptc_host host (.core_clk(core_clk), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_rd_data(rdata));

  hptc_regs DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_rd_data(rdata), .vib_timeout_irq(src[hptc_pkg::SRC_TMO]),
    .drive_supply_lockout_irq(src[hptc_pkg::SRC_UVLO]),
    .fault_change_irq(src[hptc_pkg::SRC_FLT]),
    .conv_busy_change_irq(src[hptc_pkg::SRC_BUSY]),
    .conv_done_irq(src[hptc_pkg::SRC_EOC]), .irq(irq),
    .driver_interface_mode(mode), .driver_clock_enable(clk_en),
    .pattern_ram_enable(ram_en), .driver_enable(drv_en),
    .vib_start(vib));

  // ====
  // Checking
  task automatic chk(input string nm, input logic [7:0] s,
    input logic [7:0] e);
  begin
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  end
  endtask

  task automatic final_report();
  begin
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  function automatic logic [7:0] rd_mask(input logic [7:0] x);
    case (x)
      hptc_pkg::FAULT_MASK_ADDR: rd_mask = 8'h07;
      hptc_pkg::CONV_MASK_ADDR: rd_mask = 8'h03;
      hptc_pkg::CTRL_ADDR: rd_mask = 8'hFF;
      default: rd_mask = 8'h00;
    endcase
  endfunction

  task automatic pulse(input int s);
  begin
    @(posedge core_clk);
    #1;
    src = 5'h01 << s;
    @(posedge core_clk);
    #1;
    src = 5'h00;
  end
  endtask

  // ====
  // Tests
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    for (int i = 4; i < 16; i++)
    begin
      host.rd(8'(i), w);
      chk("reset_rd", w, 8'h00);
    end
    chk("reset_out", {irq, vib, drv_en, ram_en, clk_en, 3'h0}, 8'h00);
    $display("Test reset done");
    for (int i = 0; i < 24; i++)
    begin
      v = $random(seed);
      a = 8'h07 + {6'h00, 2'($random(seed))};
      host.wr(a, v);
      host.rd(a, w);
      chk("reg_rd", w, v & rd_mask(a));
      if (a == hptc_pkg::CTRL_ADDR)
      begin
        chk("ctrl_out", {1'b0, ram_en, clk_en, mode}, v & 8'h7F);
        chk("drv_en", {7'h00, drv_en}, {7'h00, v[4:0] != 5'h00});
      end
    end
    $display("Test registers done");
    host.wr(hptc_pkg::FAULT_MASK_ADDR, 8'h00);
    host.wr(hptc_pkg::CONV_MASK_ADDR, 8'h00);
    for (int s = 0; s < hptc_pkg::N_SRC; s++)
    begin
      a = (s < 3) ? hptc_pkg::FAULT_STAT_ADDR : hptc_pkg::CONV_STAT_ADDR;
      b = 8'h01 << ((s < 3) ? s : s - 3);
      host.wr(a + 8'h03, b);
      pulse(s);
      chk("irq_on", {7'h00, irq}, 8'h01);
      host.wr(a, b);
      chk("irq_clr", {7'h00, irq}, 8'h00);
      host.wr(a + 8'h03, 8'h00);
      pulse(s);
      chk("irq_masked", {7'h00, irq}, 8'h00);
      host.rd(a, w);
      chk("status", w, b);
      host.wr(a, b);
    end
    // Event and clear in one cycle: the event must survive
    host.wr(hptc_pkg::FAULT_MASK_ADDR, 8'h01);
    fork
      host.wr(hptc_pkg::FAULT_STAT_ADDR, 8'h01);
      pulse(hptc_pkg::SRC_FLT);
    join
    host.rd(hptc_pkg::FAULT_STAT_ADDR, w);
    chk("set_wins", w, 8'h01);
    chk("irq_held", {7'h00, irq}, 8'h01);
    host.wr(hptc_pkg::FAULT_STAT_ADDR, 8'h01);
    host.wr(hptc_pkg::FAULT_MASK_ADDR, 8'h00);
    $display("Test interrupts done");
    foreach (modes[i])
    begin
      host.start_vib(modes[i]);
      chk("vib_start", {7'h00, vib}, {7'h00, i < 2});
      @(posedge core_clk);
      #1;
      chk("vib_end", {7'h00, vib}, 8'h00);
      host.wr(hptc_pkg::CTRL_ADDR, {3'b101, modes[i]});
      chk("vib_again", {7'h00, vib}, 8'h00);
      host.stop_vib();
      chk("drv_off", {7'h00, drv_en}, 8'h00);
    end
    $display("Test trigger done");
    final_report();
  end

  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule // tb_top
